//--- logic/hbd_map.svh
// Constants of the H-bridge drive control block
// Contract
// - Drive high, no short: rotation sets direction
// - Short, drive, rotation high: both high-side on
// - Short, drive, rotation low: both low-side on
// - Controller holds drive high while braking
// - Short with drive low: all switches off
// - Anti-phase: pulse on rotation, drive held high
// - Anti-phase: half duty means zero drive
// - Sign/magnitude: sign on rotation, pulse on drive
// - Sign/magnitude: zero drive is drive held low
// - Input edges at least one microsecond apart
// - At least 500 ns between transitions
// - Warning pulls low at warning temperature
// - Switches off only at shutdown temperature
// - Warning output only pulls low
// - Controller treats warning as interrupt
// - Over-current cuts switches at once
// - Periodic retry after over-current shutdown
// - Free-running 300 kHz charge-pump oscillator
// - No bootstrap: switch at most 1 kHz
// - With bootstrap: switch up to 500 kHz
// - Every input pulse at least one microsecond
`ifndef HBD_MAP_SVH
`define HBD_MAP_SVH
`define HBD_CLK_MHZ        200
`define HBD_SYNC_RST       6'h02
`define HBD_EDGE_GAP_NS    1000
`define HBD_EDGE_GAP_CYC   ((`HBD_EDGE_GAP_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_PUMP_KHZ       300
`define HBD_PUMP_HALF_CYC  ((`HBD_CLK_MHZ * 1000) / (2 * `HBD_PUMP_KHZ))
`define HBD_RETRY_US       100
`define HBD_RETRY_CYC      (`HBD_RETRY_US * `HBD_CLK_MHZ)
`define HBD_DUTY_BITS      8
`define HBD_DUTY_HALF      8'h80
`define HBD_PERIOD_CYC     200000
`endif

//--- logic/hbd_pkg.sv
// Types shared by both ends of the H-bridge drive link
package hbd_pkg;
  typedef enum logic [1:0] {
    HBD_MODE_OFF  = 2'b00,
    HBD_MODE_ANTI = 2'b01,
    HBD_MODE_SIGN = 2'b10,
    HBD_MODE_BRK  = 2'b11
  } hbd_mode_t;
  typedef enum logic [1:0] {
    HBD_RUN   = 2'b00,
    HBD_TRIP  = 2'b01,
    HBD_RETRY = 2'b10
  } hbd_oc_t;
endpackage : hbd_pkg

//--- logic/hbd_if.sv
// Pin-level link between motion controller and bridge logic
`timescale 1ns/1ps
interface hbd_if;
  logic rot_sel;
  logic short_req;
  logic drive;
  logic warn_o;
  logic warn_oe;
  logic warn_n;
  // Open-drain wire with external pull-up
  assign warn_n = warn_oe ? warn_o : 1'b1;
  modport dev  (input rot_sel, input short_req, input drive,
                output warn_o, output warn_oe);
  modport ctrl (output rot_sel, output short_req, output drive,
                input warn_n);
endinterface : hbd_if

//--- logic/hbd_bridge.sv
// Bridge end: input decode, thermal, over-current and charge pump
`timescale 1ns/1ps
`include "hbd_map.svh"
module hbd_bridge
  import hbd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  hbd_if.dev        pins,
  input  wire logic temp_warn,
  input  wire logic temp_shut,
  input  wire logic over_cur,
  output logic      hs_a_ff,
  output logic      hs_b_ff,
  output logic      ls_a_ff,
  output logic      ls_b_ff,
  output logic      pump_ff,
  output logic      oc_trip
);
  // Synchroniser reset matches the controller's idle pins: all off
  localparam logic [5:0] sync_rst = `HBD_SYNC_RST;

  logic [5:0]  raw_in;
  logic [5:0]  s1_ff;
  logic [5:0]  s2_ff;
  logic        rot_s;
  logic        brk_s;
  logic        drv_s;
  logic        warn_s;
  logic        shut_s;
  logic        oc_s;
  logic [3:0]  nxt_sw;
  logic [3:0]  sw_ff;
  logic        cut;
  logic        warn_ff;
  hbd_oc_t     oc_ff;
  hbd_oc_t     nxt_oc;
  logic [15:0] oc_cnt_ff;
  logic [9:0]  pump_cnt_ff;
  logic        pump_wrap;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers, pins and sensors alike
  assign raw_in = {over_cur, temp_shut, temp_warn,
                   pins.drive, pins.short_req, pins.rot_sel};

  // Only the second stage is read, so no logic sees a metastable bit
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        s1_ff[i] <= sync_rst[i];
        s2_ff[i] <= sync_rst[i];
      end else if (clk_en) begin
        s1_ff[i] <= raw_in[i];
        s2_ff[i] <= s1_ff[i];
      end
    end
  end

  // Named taps of the second stage
  assign rot_s  = s2_ff[0];
  assign brk_s  = s2_ff[1];
  assign drv_s  = s2_ff[2];
  assign warn_s = s2_ff[3];
  assign shut_s = s2_ff[4];
  assign oc_s   = s2_ff[5];

  ////////////////////////////////////////////////////////////////////////
  // Truth-table decode; bits 3 to 0 are hs_a, hs_b, ls_a, ls_b
  always_comb begin
    nxt_sw = 4'h0;
    case ({drv_s, brk_s})
      2'b10: begin
        // Run: rotation picks which diagonal conducts
        nxt_sw[3] = rot_s;
        nxt_sw[0] = rot_s;
        nxt_sw[1] = !rot_s;
        nxt_sw[2] = !rot_s;
      end
      2'b11: begin
        // Brake: rotation picks the rail that shorts the motor
        nxt_sw[3] = rot_s;
        nxt_sw[2] = rot_s;
        nxt_sw[1] = !rot_s;
        nxt_sw[0] = !rot_s;
      end
      2'b00: begin
        // Drive low recirculates through the supply side
        nxt_sw[3] = 1'b1;
        nxt_sw[2] = 1'b1;
      end
      default: begin
        nxt_sw = 4'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Switch stage: warning does not cut; only shutdown or a trip does
  assign cut     = shut_s || (oc_ff != HBD_RUN);
  assign oc_trip = (oc_ff != HBD_RUN);

  // Registered so decode glitches never reach a switch
  for (genvar k = 0; k < 4; k++) begin : g_switch
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sw_ff[k] <= 1'b0;
      end else if (clk_en) begin
        sw_ff[k] <= nxt_sw[k] && !cut;
      end
    end
  end

  assign hs_a_ff = sw_ff[3];
  assign hs_b_ff = sw_ff[2];
  assign ls_a_ff = sw_ff[1];
  assign ls_b_ff = sw_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // Thermal warning, open drain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      warn_ff <= 1'b0;
    end else if (clk_en) begin
      warn_ff <= warn_s;
    end
  end
  assign pins.warn_o  = 1'b0;
  assign pins.warn_oe = warn_ff;

  ////////////////////////////////////////////////////////////////////////
  // Over-current trip with timed retry
  always_comb begin
    nxt_oc = oc_ff;
    case (oc_ff)
      HBD_RUN: begin
        // Decision taken on the synchronised sensor: fastest safe path
        if (oc_s) begin
          nxt_oc = HBD_TRIP;
        end
      end
      HBD_TRIP: begin
        if (oc_cnt_ff == 16'(`HBD_RETRY_CYC - 1)) begin
          nxt_oc = HBD_RETRY;
        end
      end
      HBD_RETRY: begin
        // One try; a fault still present trips again next cycle
        nxt_oc = HBD_RUN;
      end
      default: begin
        nxt_oc = HBD_TRIP;
      end
    endcase
  end

  // State register; next state comes from the process above
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oc_ff <= HBD_RUN;
    end else if (clk_en) begin
      oc_ff <= nxt_oc;
    end
  end

  // Counting from zero each trip keeps every off time equal
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oc_cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      if (oc_ff != HBD_TRIP) begin
        oc_cnt_ff <= 16'h0000;
      end else begin
        oc_cnt_ff <= oc_cnt_ff + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge-pump oscillator, free running; frozen only by the enable
  // Half period rounds down, so the rate sits just above target
  assign pump_wrap = (pump_cnt_ff == 10'(`HBD_PUMP_HALF_CYC - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pump_cnt_ff <= 10'h000;
    end else if (clk_en) begin
      if (pump_wrap) begin
        pump_cnt_ff <= 10'h000;
      end else begin
        pump_cnt_ff <= pump_cnt_ff + 10'h001;
      end
    end
  end

  // Level flips at each wrap: one full cycle per two wraps
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pump_ff <= 1'b0;
    end else if (clk_en) begin
      if (pump_wrap) begin
        pump_ff <= !pump_ff;
      end
    end
  end
endmodule : hbd_bridge

//--- logic/hbd_ctrl.sv
// Controller end: anti-phase and sign/magnitude pulse generation
`timescale 1ns/1ps
`include "hbd_map.svh"
module hbd_ctrl
  import hbd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  hbd_if.ctrl             pins,
  input  wire hbd_mode_t  mode,
  input  wire logic [7:0] duty,
  input  wire logic       sign,
  output logic            warn_irq
);
  logic [17:0] per_ff;
  logic [17:0] gap_ff;
  logic [1:0]  w_ff;
  logic        pulse_ff;
  logic        rot_ff;
  logic        brk_ff;
  logic        drv_ff;
  logic [17:0] thr;
  logic        nxt_rot;
  logic        nxt_brk;
  logic        nxt_drv;

  // Period fixed at 1 kHz, within the no-bootstrap limit
  // Product before the shift, so half duty is exactly half the period
  assign thr = 18'((`HBD_PERIOD_CYC * duty) >> 8);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      per_ff   <= 18'h00000;
      pulse_ff <= 1'b0;
    end else if (clk_en) begin
      per_ff   <= (per_ff == 18'(`HBD_PERIOD_CYC - 1)) ?
                  18'h00000 : per_ff + 18'h00001;
      pulse_ff <= per_ff < thr;
    end
  end

  always_comb begin
    nxt_rot = rot_ff;
    nxt_brk = 1'b0;
    nxt_drv = 1'b1;
    case (mode)
      HBD_MODE_ANTI: begin
        nxt_rot = pulse_ff;
      end
      HBD_MODE_SIGN: begin
        nxt_rot = sign;
        nxt_drv = pulse_ff && (duty != 8'h00);
      end
      HBD_MODE_BRK: begin
        nxt_brk = 1'b1;
      end
      default: begin
        nxt_brk = 1'b1;
        nxt_drv = 1'b0;     // all switches off
      end
    endcase
  end

  // One output edge per gap keeps edges apart and pulses wide
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rot_ff <= 1'b0;
      brk_ff <= 1'b1;
      drv_ff <= 1'b0;
      gap_ff <= 18'h00000;
    end else if (clk_en) begin
      if (gap_ff != 18'h00000) begin
        gap_ff <= gap_ff - 18'h00001;
      end else if (nxt_rot != rot_ff) begin
        rot_ff <= nxt_rot;
        gap_ff <= 18'(`HBD_EDGE_GAP_CYC);
      end else if (nxt_brk != brk_ff) begin
        brk_ff <= nxt_brk;
        gap_ff <= 18'(`HBD_EDGE_GAP_CYC);
      end else if (nxt_drv != drv_ff) begin
        drv_ff <= nxt_drv;
        gap_ff <= 18'(`HBD_EDGE_GAP_CYC);
      end
    end
  end

  assign pins.rot_sel   = rot_ff;
  assign pins.short_req = brk_ff;
  assign pins.drive     = drv_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      w_ff <= 2'b00;
    end else if (clk_en) begin
      w_ff <= {w_ff[0], !pins.warn_n};
    end
  end
  assign warn_irq = w_ff[1];
endmodule : hbd_ctrl

//--- verification/hbd_link_assertions.sv
// Checker on the bridge link pins and bridge outputs
`timescale 1ns/1ps
module hbd_link_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rot_sel,
  input wire logic short_req,
  input wire logic drive,
  input wire logic warn_o,
  input wire logic warn_oe,
  input wire logic temp_warn,
  input wire logic temp_shut,
  input wire logic over_cur,
  input wire logic oc_trip,
  input wire logic pump_ff,
  input wire logic hs_a_ff,
  input wire logic hs_b_ff,
  input wire logic ls_a_ff,
  input wire logic ls_b_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0]  sw;
  logic [2:0]  pin;
  logic [15:0] trip_cnt_ff;
  logic [9:0]  pump_cnt_ff;
  logic        pump_q_ff;
  assign sw = {hs_a_ff, hs_b_ff, ls_a_ff, ls_b_ff};
  assign pin = {drive, short_req, rot_sel};
  function automatic logic [3:0] want(input logic [2:0] p);
    case (p)
      3'h2, 3'h3: return 4'h0;
      3'h4: return 4'h6;
      3'h5: return 4'h9;
      3'h6: return 4'h3;
      default: return 4'hc;
    endcase
  endfunction : want
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) trip_cnt_ff <= 16'h0;
    else trip_cnt_ff <= oc_trip ? trip_cnt_ff + 16'h1 : 16'h0;
  end
  // Counter restarts on each pump edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) pump_cnt_ff <= 10'h0;
    else if (clk_en)
      pump_cnt_ff <= (pump_ff != pump_q_ff) ? 10'h0 : pump_cnt_ff + 10'h1;
  end
  // Held with the enable, like the pump itself
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) pump_q_ff <= 1'b0;
    else if (clk_en) pump_q_ff <= pump_ff;
  end
  sequence s_quiet;
    ($stable(pin) && !temp_shut && !over_cur && !oc_trip) [*4];
  endsequence
  a_drive_decode: assert property (s_quiet |-> sw == want(pin))
    else $error("switch state does not match pins");
  a_trip_rise: assert property ($rose(over_cur) |-> ##[1:4] oc_trip)
    else $error("over-current not tripped");
  a_trip_off: assert property ($rose(oc_trip) |=> (sw == 4'h0) [*8])
    else $error("switches on during trip");
  a_trip_hold: assert property ($fell(oc_trip) |-> trip_cnt_ff >= 16'h4e20)
    else $error("retry came too early");
  a_warn_rise: assert property ($rose(temp_warn) |-> ##[1:4] warn_oe)
    else $error("warning not raised");
  a_warn_drop: assert property (!temp_warn [*4] |-> !warn_oe)
    else $error("warning without cause");
  a_warn_pull: assert property (warn_oe |-> !warn_o)
    else $error("warning driven high");
  a_shut_off: assert property (temp_shut [*4] |-> sw == 4'h0)
    else $error("switches on in shutdown");
  a_pump_runs: assert property (pump_cnt_ff < 10'h14e)
    else $error("charge pump stalled");
endmodule : hbd_link_assertions

//--- verification/tb.sv
// Testbench joining controller and bridge ends
`timescale 1ns/1ps
module tb;
  import hbd_pkg::*;
  logic clk_sys = 0, rst = 1, en = 1, sign = 0, warn_irq;
  logic temp_warn = 0, temp_shut = 0, over_cur = 0, oc_trip, pump;
  logic [3:0] sw, sw2;
  logic [2:0] p2 = 3'h2;
  logic [7:0] duty = 8'h0;
  hbd_mode_t mode = HBD_MODE_OFF;
  int bad_count = 0, checks_done = 0, cyc = 0;
  // Index is {drive, short_req, rot_sel}
  localparam logic [3:0] EXP [8] = '{4'hc, 4'hc, 4'h0, 4'h0,
                                     4'h6, 4'h9, 4'h3, 4'hc};
  hbd_if link ();
  hbd_if link2 ();
  assign {link2.drive, link2.short_req, link2.rot_sel} = p2;
  hbd_ctrl hbd_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(en),
    .pins(link), .mode(mode), .duty(duty), .sign(sign), .warn_irq(warn_irq));
  hbd_bridge hbd_bridge_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(en),
    .pins(link), .temp_warn(temp_warn), .temp_shut(temp_shut),
    .over_cur(over_cur), .hs_a_ff(sw[3]), .hs_b_ff(sw[2]), .ls_a_ff(sw[1]),
    .ls_b_ff(sw[0]), .pump_ff(pump), .oc_trip(oc_trip));
  // Second bridge fed straight from the bench
  hbd_bridge hbd_bridge_inst_b (.clk_sys(clk_sys), .rst(rst), .clk_en(en),
    .pins(link2), .temp_warn(1'b0), .temp_shut(1'b0), .over_cur(1'b0),
    .hs_a_ff(sw2[3]), .hs_b_ff(sw2[2]), .ls_a_ff(sw2[1]),
    .ls_b_ff(sw2[0]), .pump_ff(), .oc_trip());
  hbd_link_assertions hbd_link_assertions_inst (.clk_sys(clk_sys),
    .rst(rst), .clk_en(en), .rot_sel(link.rot_sel),
    .short_req(link.short_req),
    .drive(link.drive), .warn_o(link.warn_o), .warn_oe(link.warn_oe),
    .temp_warn(temp_warn), .temp_shut(temp_shut), .over_cur(over_cur),
    .oc_trip(oc_trip), .pump_ff(pump), .hs_a_ff(sw[3]), .hs_b_ff(sw[2]),
    .ls_a_ff(sw[1]), .ls_b_ff(sw[0]));
  always #2.5 clk_sys = ~clk_sys;
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic check(input logic [3:0] seen, input logic [3:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  // One pin per step, 1 us apart
  task automatic test_decode();
    for (int i = 0; i < 8; i++) begin
      for (int b = 0; b < 3; b++) begin
        if (p2[b] !== i[b]) begin
          p2[b] = i[b];
          tick(201);
        end
      end
      check(sw2, EXP[i], "decode");
    end
    $display("test decode done");
  endtask : test_decode
  task automatic test_modes();
    mode = HBD_MODE_SIGN;
    sign = 1;
    tick(1000);
    check({1'b0, link.short_req, link.drive, link.rot_sel}, 4'h1, "sign");
    mode = HBD_MODE_BRK;
    tick(1000);
    check({2'h0, link.short_req, link.drive}, 4'h3, "brake");
    mode = HBD_MODE_ANTI;
    duty = 8'h80;
    tick(1000);
    check({3'h0, link.drive}, 4'h1, "anti");
    $display("test modes done");
  endtask : test_modes
  task automatic test_thermal();
    temp_warn = 1;
    tick(10);
    check({2'h0, link.warn_n, warn_irq}, 4'h1, "warn");
    check({3'h0, sw != 4'h0}, 4'h1, "warn run");
    temp_shut = 1;
    tick(10);
    check(sw, 4'h0, "shut");
    temp_warn = 0;
    temp_shut = 0;
    tick(10);
    check({3'h0, link.warn_n}, 4'h1, "warn off");
    $display("test thermal done");
  endtask : test_thermal
  task automatic test_overcur();
    over_cur = 1;
    tick(10);
    check({oc_trip, sw[2:0]}, 4'h8, "trip");
    over_cur = 0;
    tick(19000);
    check({3'h0, oc_trip}, 4'h1, "hold");
    tick(1100);
    check({3'h0, oc_trip | sw == 4'h0}, 4'h0, "retry");
    $display("test overcur done");
  endtask : test_overcur
  // Enable low must hold every register, pump included
  task automatic test_freeze();
    logic pump_held;
    pump_held = pump;
    en = 0;
    tick(400);
    check({3'h0, pump}, {3'h0, pump_held}, "freeze pump");
    check(sw, 4'h9, "freeze switches");
    en = 1;
    tick(333);
    check({3'h0, pump}, {3'h0, !pump_held}, "pump resumes");
    $display("test freeze done");
  endtask : test_freeze
  initial begin
    tick(8);
    rst = 0;
    test_decode();
    test_modes();
    test_thermal();
    test_overcur();
    test_freeze();
    give_verdict();
  end
endmodule : tb
